// ===== core/emirq_defines.svh
// Constants of the external-memory interrupt status block.
// Assumes a 32-bit AHB-Lite bus, word registers, one 125 MHz clock.
`ifndef EMIRQ_DEFINES_SVH
`define EMIRQ_DEFINES_SVH

// Register byte offsets
`define EMIRQ_OFS_RAW 5'h00
`define EMIRQ_OFS_MASKED 5'h04
`define EMIRQ_OFS_EN_SET 5'h08
`define EMIRQ_OFS_EN_CLR 5'h0c
`define EMIRQ_OFS_WAIT_CFG 5'h10
`define EMIRQ_OFS_STATE 5'h14

// Field positions
`define EMIRQ_BIT_TIMEOUT 0
`define EMIRQ_BIT_WAIT_RISE 2
`define EMIRQ_FLAG_MASK 3'h5
`define EMIRQ_MAX_EXT_WAIT_COUNT_MSB 7
`define EMIRQ_ST_WAIT 0
`define EMIRQ_ST_ACCESS 1
`define EMIRQ_ST_ABANDON 2
`define EMIRQ_ST_CNT_LSB 16

// Reset values
`define EMIRQ_RST_FLAGS 3'h0
`define EMIRQ_RST_EN 3'h0
`define EMIRQ_RST_MAX_EXT_WAIT_COUNT 8'h00

// Timing
`define EMIRQ_WAIT_MULT 16
`define EMIRQ_CNT_W 13

`endif

// ===== core/emirq_pkg.sv
// Types of the external-memory interrupt status block.
// Assumes emirq_defines.svh for the counter width; flag width and select codes are literal.
`include "emirq_defines.svh"
package emirq_pkg;
  typedef logic [2:0] emirq_flags_t;
  typedef logic [`EMIRQ_CNT_W-1:0] emirq_cnt_t;
  typedef enum logic [5:0] {
    EMIRQ_SEL_RAW = 6'h01,
    EMIRQ_SEL_MASKED = 6'h02,
    EMIRQ_SEL_EN_SET = 6'h04,
    EMIRQ_SEL_EN_CLR = 6'h08,
    EMIRQ_SEL_WAIT_CFG = 6'h10,
    EMIRQ_SEL_STATE = 6'h20
  } emirq_sel_t;
endpackage

// ===== core/emirq_if.sv
// Carrier between the status top and its wait-timeout counter.
// Assumes one clock; all signals are synchronous to it.
`timescale 1ns/10ps
`default_nettype none
`include "emirq_defines.svh"
interface emirq_if;
  logic [7:0] max_ext_wait_count;
  logic access_active;
  logic wait_level;
  logic timeout_pulse;
  logic abandon;
  logic [`EMIRQ_CNT_W-1:0] wait_count;
  modport tmr (
    input max_ext_wait_count, access_active, wait_level,
    output timeout_pulse, abandon, wait_count
  );
  modport ctl (
    output max_ext_wait_count, access_active, wait_level,
    input timeout_pulse, abandon, wait_count
  );
endinterface
`default_nettype wire

// ===== core/emirq_timeout.sv
// Extended-wait timeout counter.
// Assumes access_active covers the strobe phase of an extended-wait access.
`timescale 1ns/10ps
`default_nettype none
`include "emirq_defines.svh"
module emirq_timeout
  import emirq_pkg::*;
#(
  parameter int WAIT_MULT = `EMIRQ_WAIT_MULT
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Counter side of the carrier
  emirq_if.tmr t
);
  emirq_cnt_t count_r;
  emirq_cnt_t thr_m1;
  logic fired_r;
  logic pulse_r;
  logic waiting;
  logic hit;

  // Limit is (count + 1) * multiple, so never zero
  assign thr_m1 = `EMIRQ_CNT_W'(({5'h00, t.max_ext_wait_count} + 13'h0001) * `EMIRQ_CNT_W'(WAIT_MULT)
                  - 13'h0001);
  assign waiting = t.access_active & t.wait_level;
  assign hit = waiting & ~fired_r & (count_r == thr_m1);

  always_ff @(posedge clk) begin
    if (!resetn || !waiting) begin
      count_r <= '0;
    end else if (!fired_r && count_r != thr_m1) begin
      count_r <= count_r + 13'h0001;
    end
  end

  // One timeout per access; cleared when the access ends
  always_ff @(posedge clk) begin
    if (!resetn) begin
      fired_r <= 1'b0;
      pulse_r <= 1'b0;
    end else begin
      fired_r <= t.access_active & (fired_r | hit);
      pulse_r <= hit;
    end
  end

  assign t.timeout_pulse = pulse_r;
  assign t.abandon = fired_r;
  assign t.wait_count = count_r;
endmodule // emirq_timeout
`default_nettype wire

// ===== core/emirq_top.sv
// External-memory interrupt status block with AHB-Lite register slave.
// Assumes the access sequencer drives ext_access_active and honours
// ext_wait_abandon; ext_wait_in is already synchronous to clk.
`timescale 1ns/10ps
`default_nettype none
`include "emirq_defines.svh"
module emirq_top
  import emirq_pkg::*;
#(
  parameter int WAIT_MULT = `EMIRQ_WAIT_MULT,
  parameter logic [7:0] MAX_EXT_WAIT_COUNT_RESET = `EMIRQ_RST_MAX_EXT_WAIT_COUNT
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // External memory side
  input wire logic ext_wait_in,
  input wire logic ext_access_active,
  output logic ext_wait_abandon,
  // Interrupt controller side
  output logic irq,
  output logic irq_pulse
);

  emirq_if tif ();

  // Address decode, shared by read and write paths
  function automatic emirq_sel_t emirq_decode(input logic [4:0] ofs);
    emirq_sel_t s;
    s = EMIRQ_SEL_RAW;
    if (ofs == `EMIRQ_OFS_RAW) begin
      s = EMIRQ_SEL_RAW;
    end else if (ofs == `EMIRQ_OFS_MASKED) begin
      s = EMIRQ_SEL_MASKED;
    end else if (ofs == `EMIRQ_OFS_EN_SET) begin
      s = EMIRQ_SEL_EN_SET;
    end else if (ofs == `EMIRQ_OFS_EN_CLR) begin
      s = EMIRQ_SEL_EN_CLR;
    end else if (ofs == `EMIRQ_OFS_WAIT_CFG) begin
      s = EMIRQ_SEL_WAIT_CFG;
    end else begin
      s = EMIRQ_SEL_STATE;
    end
    return s;
  endfunction

  // Offset hit test, needed for the unmapped-address answer
  function automatic logic emirq_mapped(input logic [31:0] a);
    return (a[31:5] == 27'h0000000) && (a[4:0] <= `EMIRQ_OFS_STATE) && (a[1:0] == 2'h0);
  endfunction

  // Bus state
  logic hready_r;
  logic [31:0] hrdata_r;
  logic wr_pend_r;
  logic wr_hit_r;
  logic [4:0] wr_ofs_r;

  // Block state
  emirq_flags_t raw_r;
  emirq_flags_t masked_r;
  emirq_flags_t en_r;
  logic [7:0] max_ext_wait_count_r;
  logic wait_d_r;
  logic irq_r;
  logic pulse_r;
  logic abandon_r;

  // Next values
  emirq_flags_t raw_nxt;
  emirq_flags_t masked_nxt;
  emirq_flags_t en_nxt;
  logic [7:0] max_ext_wait_count_nxt;
  logic [31:0] hrdata_nxt;

  // Decode wires
  logic addr_phase;
  logic rd_take;
  logic wr_take;
  logic wr_go;
  emirq_sel_t wr_sel;
  emirq_sel_t rd_sel;
  logic rd_hit;
  emirq_flags_t wdata_flags;
  emirq_flags_t clr_raw;
  emirq_flags_t clr_masked;
  emirq_flags_t clr_all;
  emirq_flags_t ev;
  emirq_flags_t ev_en;
  emirq_flags_t newly_set;
  logic wait_rise;
  logic [31:0] state_word;

  // AHB address phase; only whole-word transfers are meaningful
  // hsize is not decoded, so a narrow write still acts on the whole word
  assign addr_phase = hsel & htrans[1] & hready;
  assign rd_take = addr_phase & ~hwrite;
  assign wr_take = addr_phase & hwrite;
  assign rd_hit = emirq_mapped(haddr);
  assign rd_sel = emirq_decode(haddr[4:0]);
  assign wr_sel = emirq_decode(wr_ofs_r);
  assign wr_go = wr_pend_r & wr_hit_r;

  // Only the flag positions can be written; reserved bits are dropped
  assign wdata_flags = hwdata[2:0] & `EMIRQ_FLAG_MASK;

  // Write-one-to-clear, zeros have no effect
  assign clr_raw = (wr_go && wr_sel == EMIRQ_SEL_RAW) ? wdata_flags : 3'h0;
  assign clr_masked = (wr_go && wr_sel == EMIRQ_SEL_MASKED) ? wdata_flags : 3'h0;
  // Either register's clear reaches both
  assign clr_all = clr_raw | clr_masked;

  // Events
  assign wait_rise = ext_wait_in & ~wait_d_r;
  assign ev[`EMIRQ_BIT_WAIT_RISE] = wait_rise;
  assign ev[`EMIRQ_BIT_TIMEOUT] = tif.timeout_pulse;
  // Bit 1 is reserved and has no source
  assign ev[1] = 1'b0;
  assign ev_en = ev & en_r;

  // Per-flag cells; set wins over a clear in the same cycle
  for (genvar gi = 0; gi < 3; gi++) begin : g_flag
    assign raw_nxt[gi] = (raw_r[gi] & ~clr_all[gi]) | ev[gi];
    assign masked_nxt[gi] = (masked_r[gi] & ~clr_all[gi]) | ev_en[gi];
    assign newly_set[gi] = masked_nxt[gi] & ~masked_r[gi];
  end

  // Enable set and clear registers, each a one-shot write of ones
  assign en_nxt = (wr_go && wr_sel == EMIRQ_SEL_EN_SET) ? (en_r | wdata_flags) :
                  (wr_go && wr_sel == EMIRQ_SEL_EN_CLR) ? (en_r & ~wdata_flags) : en_r;
  assign max_ext_wait_count_nxt = (wr_go && wr_sel == EMIRQ_SEL_WAIT_CFG) ? hwdata[`EMIRQ_MAX_EXT_WAIT_COUNT_MSB:0] : max_ext_wait_count_r;

  // Live state word
  assign state_word = {3'h0, tif.wait_count, 13'h0000, tif.abandon, ext_access_active, wait_d_r};

  // Read mux; unmapped reads give zero
  always_comb begin
    hrdata_nxt = 32'h0000_0000;
    if (rd_take && rd_hit) begin
      unique case (rd_sel)
        EMIRQ_SEL_RAW: hrdata_nxt = {29'h0000_0000, raw_r};
        EMIRQ_SEL_MASKED: hrdata_nxt = {29'h0000_0000, masked_r};
        EMIRQ_SEL_EN_SET: hrdata_nxt = {29'h0000_0000, en_r};
        EMIRQ_SEL_EN_CLR: hrdata_nxt = {29'h0000_0000, en_r};
        EMIRQ_SEL_WAIT_CFG: hrdata_nxt = {24'h00_0000, max_ext_wait_count_r};
        EMIRQ_SEL_STATE: hrdata_nxt = state_word;
      endcase
    end
  end

  // Carrier to the timeout counter
  assign tif.max_ext_wait_count = max_ext_wait_count_r;
  assign tif.access_active = ext_access_active;
  // Counter sees the registered wait level, one edge behind the pin
  assign tif.wait_level = wait_d_r;

  emirq_timeout #(
    .WAIT_MULT(WAIT_MULT)
  ) u_timeout (
    .clk(clk),
    .resetn(resetn),
    .t(tif.tmr)
  );

  // Ready held low in reset; zero-wait slave afterwards, always OKAY
  always_ff @(posedge clk) begin
    if (!resetn) begin
      hready_r <= 1'b0;
    end else begin
      hready_r <= 1'b1;
    end
  end

  // Read word reloaded every edge, zero when no read is taken
  always_ff @(posedge clk) begin
    if (!resetn) begin
      hrdata_r <= 32'h0000_0000;
    end else begin
      hrdata_r <= hrdata_nxt;
    end
  end

  // Write held over to the data phase, where hwdata arrives
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wr_pend_r <= 1'b0;
    end else begin
      wr_pend_r <= wr_take;
    end
  end

  // Unmapped writes dropped here, so they never alias a register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wr_hit_r <= 1'b0;
    end else begin
      wr_hit_r <= wr_take & rd_hit;
    end
  end

  // Offset of the pending write
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wr_ofs_r <= 5'h00;
    end else begin
      wr_ofs_r <= haddr[4:0];
    end
  end

  // Raw flags
  always_ff @(posedge clk) begin
    if (!resetn) begin
      raw_r <= `EMIRQ_RST_FLAGS;
    end else begin
      raw_r <= raw_nxt;
    end
  end

  // Masked flags
  always_ff @(posedge clk) begin
    if (!resetn) begin
      masked_r <= `EMIRQ_RST_FLAGS;
    end else begin
      masked_r <= masked_nxt;
    end
  end

  // Enables, one register behind both the set and the clear view
  always_ff @(posedge clk) begin
    if (!resetn) begin
      en_r <= `EMIRQ_RST_EN;
    end else begin
      en_r <= en_nxt;
    end
  end

  // Wait count; its reset value is a parameter
  always_ff @(posedge clk) begin
    if (!resetn) begin
      max_ext_wait_count_r <= MAX_EXT_WAIT_COUNT_RESET;
    end else begin
      max_ext_wait_count_r <= max_ext_wait_count_nxt;
    end
  end

  // Wait level one edge back; resets low, the idle level, so no false rise
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wait_d_r <= 1'b0;
    end else begin
      wait_d_r <= ext_wait_in;
    end
  end

  // Interrupt level, high while any masked flag stands
  always_ff @(posedge clk) begin
    if (!resetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |masked_nxt;
    end
  end

  // One-cycle pulse for each cycle that newly sets any masked flag
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pulse_r <= 1'b0;
    end else begin
      pulse_r <= |newly_set;
    end
  end

  // Abandon follows the counter one edge late
  always_ff @(posedge clk) begin
    if (!resetn) begin
      abandon_r <= 1'b0;
    end else begin
      abandon_r <= tif.abandon;
    end
  end

  assign hreadyout = hready_r;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;
  assign irq = irq_r;
  assign irq_pulse = pulse_r;
  assign ext_wait_abandon = abandon_r;

endmodule // emirq_top
`default_nettype wire

// ===== verification/emirq_top_asserts.sv
// Checker of the interrupt status block.
// Assumes bind to emirq_top.
`timescale 1ns/10ps
`default_nettype none
module emirq_top_asserts (
  // Clock, reset
  input wire logic clk,
  input wire logic resetn,
  // Bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // Events, interrupt
  input wire logic ext_wait_in,
  input wire logic ext_access_active,
  input wire logic ext_wait_abandon,
  input wire logic irq,
  input wire logic irq_pulse
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  wire take = hsel && htrans[1] && hready;
  wire st_a = haddr == 32'h0 || haddr == 32'h4;
  // Quiet inputs, so no event races the write
  wire quiet = !ext_wait_in && !ext_access_active && !ext_wait_abandon;
  logic st_wr_r;
  always_ff @(posedge clk) st_wr_r <= resetn && take && hwrite && st_a;
  sequence rd_st;
    take && !hwrite && st_a;
  endsequence
  a_pulse_short: assert property (irq_pulse |=> !irq_pulse) else $error("pulse long");
  a_pulse_rise: assert property ($rose(irq) |-> irq_pulse) else $error("no pulse");
  a_pulse_irq: assert property (irq_pulse |-> irq) else $error("pulse no irq");
  a_pulse_cause: assert property (irq_pulse |->
    $past(ext_wait_in) && !$past(ext_wait_in, 2) || ext_wait_abandon) else $error("stray pulse");
  a_clear_both: assert property (st_wr_r && hwdata[2:0] == 3'h5 && quiet &&
    !$past(ext_wait_in) |=> !irq) else $error("irq kept");
  a_zero_keeps: assert property (st_wr_r && hwdata[2:0] == 3'h0 && quiet &&
    !$past(ext_wait_in) |=> $stable(irq)) else $error("zero write acted");
  a_rsvd_zero: assert property (rd_st |=> hrdata[31:3] == 29'h0 && !hrdata[1]) else $error("rsvd");
  a_abandon_end: assert property ($fell(ext_access_active) |-> ##[1:3] !ext_wait_abandon)
    else $error("abandon held");
  a_ready_up: assert property ($past(resetn) |-> hreadyout && !hresp) else $error("bus stalled");
endmodule // emirq_top_asserts
bind emirq_top emirq_top_asserts u_chk (.clk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hwdata,
  .hreadyout, .hresp, .hrdata, .ext_wait_in, .ext_access_active, .ext_wait_abandon, .irq, .irq_pulse);
`default_nettype wire

// ===== verification/emirq_mem_model.sv
// Memory side: wait source and access sequencer.
// Assumes tasks are called just after a rising edge.
`timescale 1ns/10ps
`default_nettype none
module emirq_mem_model (
  // Clock
  input wire logic clk,
  // Memory side
  output logic ext_wait_in,
  output logic ext_access_active
);
  initial begin
    ext_wait_in = 1'b0;
    ext_access_active = 1'b0;
  end
  task automatic wait_pulse();
    ext_wait_in <= 1'b1;
    repeat (4) @(posedge clk);
    ext_wait_in <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  // Wait held for the whole n-cycle access, so the block gives up only if n outlasts the timeout
  task automatic stuck_access(input int n);
    ext_access_active <= 1'b1;
    ext_wait_in <= 1'b1;
    repeat (n) @(posedge clk);
    ext_access_active <= 1'b0;
    ext_wait_in <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
endmodule // emirq_mem_model
`default_nettype wire

// ===== verification/ext_mem_irq_status_tb_top.sv
// Self-checking bench of the interrupt status block.
// Assumes the checker binds itself.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin failures++; \
  $display("wrong value at %0t: %h not %h", $time, a, e); end end
module ext_mem_irq_status_tb_top;
  typedef struct {logic w; logic [31:0] a; logic [31:0] d; logic [31:0] e;} emirq_row_t;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  wire hreadyout, hresp, irq, irq_pulse, wt, acc, abandon;
  wire [31:0] hrdata;
  int failures = 0;
  int total_checks = 0;
  int pulses = 0;
  int cycles = 0;
  logic abandon_seen = 1'b0;
  logic [31:0] q;
  emirq_row_t rows [15] = '{'{0, 32'h00, 0, 0}, '{0, 32'h04, 0, 0}, '{0, 32'h08, 0, 0},
    '{0, 32'h10, 0, 0}, '{1, 32'h08, 5, 0}, '{0, 32'h0c, 0, 5}, '{1, 32'h0c, 1, 0},
    '{0, 32'h08, 0, 4}, '{1, 32'h10, 3, 0}, '{0, 32'h10, 0, 3}, '{1, 32'h10, 0, 0},
    '{0, 32'h40, 0, 0}, '{1, 32'h40, 1, 0}, '{0, 32'h08, 0, 4}, '{0, 32'h14, 0, 0}};
  always #4 clk = ~clk;
  emirq_mem_model u_mem (.clk(clk), .ext_wait_in(wt), .ext_access_active(acc));
  emirq_top #(.WAIT_MULT(16)) DUT (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .ext_wait_in(wt), .ext_access_active(acc),
    .ext_wait_abandon(abandon), .irq(irq), .irq_pulse(irq_pulse));
  task automatic close_out();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  always @(negedge clk) begin
    if (irq_pulse === 1'b1) pulses++;
    if (abandon === 1'b1) abandon_seen = 1'b1;
    cycles++;
    if (cycles == 3000) begin
      failures++;
      close_out();
    end
  end
  // Sampled off the edge, same value the edge sees
  task automatic phase(output logic [31:0] d);
    logic r;
    do begin
      @(negedge clk);
      d = hrdata;
      r = hreadyout;
      @(posedge clk);
    end while (r !== 1'b1);
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] rd);
    logic [31:0] x;
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    phase(x);
    htrans <= 2'h0;
    hwdata <= d;
    phase(rd);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    foreach (rows[i]) begin
      bus(rows[i].w, rows[i].a, rows[i].d, q);
      if (!rows[i].w) `CHK(q, rows[i].e)
    end
    u_mem.wait_pulse();
    bus(1'b0, 32'h0, 32'h0, q);
    `CHK(q, 32'h4)
    bus(1'b0, 32'h4, 32'h0, q);
    `CHK(q, 32'h4)
    `CHK(irq, 1'b1)
    `CHK(pulses, 1)
    bus(1'b1, 32'h0, 32'h0, q);
    bus(1'b0, 32'h0, 32'h0, q);
    `CHK(q, 32'h4)
    bus(1'b1, 32'h4, 32'h5, q);
    bus(1'b0, 32'h0, 32'h0, q);
    `CHK(q, 32'h0)
    `CHK(irq, 1'b0)
    bus(1'b1, 32'hc, 32'h4, q);
    bus(1'b1, 32'h8, 32'h1, q);
    u_mem.stuck_access(12);
    bus(1'b0, 32'h0, 32'h0, q);
    `CHK(q, 32'h4)
    `CHK(abandon_seen, 1'b0)
    bus(1'b1, 32'h0, 32'h4, q);
    u_mem.stuck_access(40);
    `CHK(abandon_seen, 1'b1)
    `CHK(abandon, 1'b0)
    bus(1'b0, 32'h0, 32'h0, q);
    `CHK(q, 32'h5)
    bus(1'b0, 32'h4, 32'h0, q);
    `CHK(q, 32'h1)
    `CHK(pulses, 2)
    bus(1'b1, 32'h0, 32'h5, q);
    bus(1'b0, 32'h4, 32'h0, q);
    `CHK(q, 32'h0)
    close_out();
  end
endmodule // ext_mem_irq_status_tb_top
`default_nettype wire
